// ==== include/ivw_params.svh ====
// Constants for the interrupt vector and wakeup map
`ifndef IVW_PARAMS_SVH
`define IVW_PARAMS_SVH

`define IVW_NUM_IRQ        30
`define IVW_VEC_RESET      24'h008000
`define IVW_VEC_TRAP       24'h008004
`define IVW_VEC_BASE       24'h008008
`define IVW_VEC_STEP       24'h000004
// Per-source wakeup masks, bit n is interrupt n
`define IVW_WAKE_HALT      30'h2400FFC0
`define IVW_WAKE_TIMED     30'h2400FFD0
`define IVW_WAKE_WAIT      30'h3E7CFFD2
`define IVW_RESERVED_MASK  30'h0183002D

`endif

// ==== include/ivw_pkg.sv ====
// Types for the interrupt vector and wakeup map
`default_nettype none
package ivw_pkg;
  typedef enum logic [2:0] {
    IVW_RUN   = 3'h0,
    IVW_WFI   = 3'h1,
    IVW_WFE   = 3'h3,
    IVW_TIMED = 3'h2,
    IVW_HALT  = 3'h6
  } ivw_power_t;

  typedef enum logic [1:0] {
    IVW_IDLE   = 2'h0,
    IVW_OFFER  = 2'h1,
    IVW_RETURN = 2'h3
  } ivw_state_t;
endpackage
`default_nettype wire

// ==== include/ivw_req_if.sv ====
// Carrier between the top and the request synchroniser
`timescale 1ns/1ps
`default_nettype none
interface ivw_req_if;
  logic [29:0] raw;
  logic [29:0] clean;
  modport sync (input raw, output clean);
  modport top  (output raw, input clean);
endinterface
`default_nettype wire

// ==== rtl/ivw_sync.sv ====
// Three-stage synchroniser for peripheral request lines
`timescale 1ns/1ps
`default_nettype none
module ivw_sync
  import ivw_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Request lines
  ivw_req_if.sync  req
);
  logic [29:0] s1;
  logic [29:0] s2;
  logic [29:0] s3;
  logic [29:0] held;
  logic [29:0] next_held;

  // A change counts only once stages two and three agree
  always_comb begin
    next_held = held;
    for (int i = 0; i < 30; i++) begin
      if (s2[i] == s3[i]) begin
        next_held[i] = s3[i];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s1   <= 30'h00000000;
      s2   <= 30'h00000000;
      s3   <= 30'h00000000;
      held <= 30'h00000000;
    end else begin
      s1   <= req.raw;
      s2   <= s1;
      s3   <= s2;
      held <= next_held;
    end
  end

  assign req.clean = held;
endmodule // ivw_sync
`default_nettype wire

// ==== rtl/irq_vector_wakeup_map.sv ====
// Interrupt vector and low-power wakeup map
`timescale 1ns/1ps
`default_nettype none
`include "ivw_params.svh"
module irq_vector_wakeup_map
  import ivw_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Peripheral request lines, bit n is interrupt n
  input  wire logic [29:0] periphReq,
  input  wire logic [29:0] irqEnable,
  input  wire logic        i2cAddrMatch,
  input  wire logic        resetReq,
  input  wire logic        trapReq,
  // Core power state and vector handshake
  input  wire logic [2:0]  powerState,
  input  wire logic        vectorAck,
  output logic             vectorValid,
  output logic [23:0]      vectorAddr,
  output logic             wakeCore,
  output logic             returnToEventWait
);
  // ----------------------------------------------------------------
  // Synchronised requests
  // ----------------------------------------------------------------
  ivw_req_if reqBus ();
  assign reqBus.raw = periphReq & ~`IVW_RESERVED_MASK;
  ivw_sync u_sync (
    .clock (clock),
    .rst_b (rst_b),
    .req   (reqBus.sync)
  );

  // ----------------------------------------------------------------
  // Wakeup decision
  // ----------------------------------------------------------------
  logic [29:0] wakeMask;
  logic [29:0] pending;
  logic        anyWake;

  always_comb begin
    case (ivw_power_t'(powerState))
      IVW_HALT:  wakeMask = `IVW_WAKE_HALT;
      IVW_TIMED: wakeMask = `IVW_WAKE_TIMED;
      IVW_WFI:   wakeMask = `IVW_WAKE_WAIT;
      IVW_WFE:   wakeMask = `IVW_WAKE_WAIT;
      default:   wakeMask = 30'h3FFFFFFF;
    endcase
    // I2C wakes a halt state only on its own address
    if ((powerState == IVW_HALT || powerState == IVW_TIMED) && !i2cAddrMatch) begin
      wakeMask[29] = 1'b0;
    end
  end

  // Only enabled sources count, including in event wait
  assign pending = reqBus.clean & irqEnable & ~`IVW_RESERVED_MASK;
  assign anyWake = |(pending & wakeMask);

  // ----------------------------------------------------------------
  // Priority pick and vector offer
  // ----------------------------------------------------------------
  logic [4:0]  pickIdx;
  logic        pickAny;
  logic [29:0] eligible;

  // In a low-power state a source that cannot wake it must not steal the vector
  assign eligible = pending & wakeMask;

  always_comb begin
    pickIdx = 5'h00;
    pickAny = 1'b0;
    for (int i = 29; i >= 0; i--) begin
      if (eligible[i]) begin
        pickIdx = 5'(i);
        pickAny = 1'b1;
      end
    end
  end

  ivw_state_t  state;
  ivw_state_t  next_state;
  logic        next_vectorValid;
  logic [23:0] next_vectorAddr;
  logic        next_wakeCore;
  logic        next_returnToEventWait;
  logic        fromEventWait;
  logic        next_fromEventWait;

  always_comb begin
    next_state             = state;
    next_vectorValid       = vectorValid;
    next_vectorAddr        = vectorAddr;
    next_wakeCore          = 1'b0;
    next_returnToEventWait = 1'b0;
    next_fromEventWait     = fromEventWait;
    case (state)
      IVW_IDLE: begin
        if (resetReq) begin
          next_wakeCore    = 1'b1;
          next_vectorAddr  = `IVW_VEC_RESET;
          next_vectorValid = 1'b1;
          next_state       = IVW_OFFER;
          next_fromEventWait = 1'b0;
        end else if (trapReq && powerState == IVW_RUN) begin
          next_vectorAddr  = `IVW_VEC_TRAP;
          next_vectorValid = 1'b1;
          next_state       = IVW_OFFER;
          next_fromEventWait = 1'b0;
        end else if (pickAny && (powerState == IVW_RUN || anyWake)) begin
          next_wakeCore    = (powerState != IVW_RUN);
          next_vectorAddr  = `IVW_VEC_BASE + (24'(pickIdx) << 2);
          next_vectorValid = 1'b1;
          next_state       = IVW_OFFER;
          next_fromEventWait = (powerState == IVW_WFE);
        end
      end
      IVW_OFFER: begin
        if (vectorAck) begin
          next_vectorValid = 1'b0;
          next_state       = fromEventWait ? IVW_RETURN : IVW_IDLE;
        end
      end
      IVW_RETURN: begin
        // Serviced from event wait: core goes back there
        next_returnToEventWait = 1'b1;
        next_fromEventWait     = 1'b0;
        next_state             = IVW_IDLE;
      end
      default: next_state = IVW_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state             <= IVW_IDLE;
      vectorValid       <= 1'b0;
      vectorAddr        <= 24'h000000;
      wakeCore          <= 1'b0;
      returnToEventWait <= 1'b0;
      fromEventWait     <= 1'b0;
    end else begin
      state             <= next_state;
      vectorValid       <= next_vectorValid;
      vectorAddr        <= next_vectorAddr;
      wakeCore          <= next_wakeCore;
      returnToEventWait <= next_returnToEventWait;
      fromEventWait     <= next_fromEventWait;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_reset_vec;
    @(posedge clock) disable iff (!rst_b)
      (state == IVW_IDLE && resetReq) |=> (vectorAddr == 24'h008000 && wakeCore && vectorValid);
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset vector wrong");

  property p_trap_nowake;
    @(posedge clock) disable iff (!rst_b)
      (vectorValid && vectorAddr == 24'h008004) |-> !wakeCore;
  endproperty
  a_trap_nowake: assert property (p_trap_nowake) else $error("trap woke core");

  property p_reserved_never;
    @(posedge clock) disable iff (!rst_b)
      vectorValid |-> !(vectorAddr inside {24'h008008, 24'h008010, 24'h008014, 24'h00801C,
        24'h008048, 24'h00804C, 24'h008064, 24'h008068});
  endproperty
  a_reserved_never: assert property (p_reserved_never) else $error("reserved vector");

  property p_halt_only_allowed;
    @(posedge clock) disable iff (!rst_b)
      ($rose(wakeCore) && $past(powerState) == IVW_HALT && !$past(resetReq))
        |-> (vectorAddr inside {[24'h008020:24'h008044], 24'h008070, 24'h00807C});
  endproperty
  a_halt_only_allowed: assert property (p_halt_only_allowed) else $error("bad halt wake");

  property p_timer4_timed;
    @(posedge clock) disable iff (!rst_b)
      ($rose(wakeCore) && $past(powerState) == IVW_TIMED && vectorAddr == 24'h008018)
        |-> $past(pending[4]);
  endproperty
  a_timer4_timed: assert property (p_timer4_timed) else $error("timer wake wrong");

  property p_i2c_halt;
    @(posedge clock) disable iff (!rst_b)
      ($rose(wakeCore) && vectorAddr == 24'h00807C && $past(powerState) == IVW_HALT)
        |-> $past(i2cAddrMatch);
  endproperty
  a_i2c_halt: assert property (p_i2c_halt) else $error("i2c woke halt");

  property p_wfe_return;
    @(posedge clock) disable iff (!rst_b)
      (state == IVW_OFFER && vectorAck && fromEventWait) |-> ##2 returnToEventWait;
  endproperty
  a_wfe_return: assert property (p_wfe_return) else $error("no return to wfe");

  property p_lowest_first;
    @(posedge clock) disable iff (!rst_b)
      (state == IVW_IDLE && !resetReq && !trapReq && pending[6] && pending[26]
        && pending[5:0] == 6'h00 && powerState == IVW_RUN) |=> (vectorAddr == 24'h008020);
  endproperty
  a_lowest_first: assert property (p_lowest_first) else $error("priority wrong");
endmodule // irq_vector_wakeup_map
`default_nettype wire

// ==== verif/ivw_core_model.sv ====
// Core model that takes offered vectors after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module ivw_core_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Vector handshake
  input  wire logic        vectorValid,
  input  wire logic [23:0] vectorAddr,
  input  wire logic [1:0]  ackDelay,
  output logic             vectorAck,
  output logic [23:0]      takenAddr
);
  int waitCnt = 0;

  initial begin
    vectorAck = 1'b0;
    takenAddr = 24'h000000;
  end

  // Ack held until the edge that drops valid, so it is never released early
  always @(posedge clock) begin
    if (vectorAck && vectorValid) takenAddr <= vectorAddr;
    #1;
    if (!rst_b || !vectorValid) begin
      vectorAck = 1'b0;
      waitCnt = ackDelay;
    end else if (waitCnt == 0) vectorAck = 1'b1;
    else waitCnt--;
  end
endmodule // ivw_core_model
`default_nettype wire

// ==== verif/irq_vector_wakeup_map_tb.sv ====
// Self-checking bench for the interrupt vector and wakeup map
`timescale 1ns/1ps
`default_nettype none
module irq_vector_wakeup_map_tb
  import ivw_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [29:0] periphReq = '0;
  logic [29:0] irqEnable = '0;
  logic        i2cAddrMatch = 1'b0;
  logic        resetReq = 1'b0;
  logic        trapReq = 1'b0;
  logic [2:0]  powerState = 3'h0;
  logic [1:0]  ackDelay = 2'h0;
  logic        vectorAck, vectorValid, wakeCore, returnToEventWait;
  logic [23:0] vectorAddr, takenAddr;
  int          miscompares = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          lo;
  ivw_power_t  pList[5] = '{IVW_RUN, IVW_WFI, IVW_WFE, IVW_TIMED, IVW_HALT};

  always #2 clock = ~clock;

  irq_vector_wakeup_map dut (.clock(clock), .rst_b(rst_b), .periphReq(periphReq),
    .irqEnable(irqEnable), .i2cAddrMatch(i2cAddrMatch), .resetReq(resetReq),
    .trapReq(trapReq), .powerState(powerState), .vectorAck(vectorAck),
    .vectorValid(vectorValid), .vectorAddr(vectorAddr), .wakeCore(wakeCore),
    .returnToEventWait(returnToEventWait));
  ivw_core_model core (.clock(clock), .rst_b(rst_b), .vectorValid(vectorValid),
    .vectorAddr(vectorAddr), .ackDelay(ackDelay), .vectorAck(vectorAck),
    .takenAddr(takenAddr));

  // ----------------------------------------
  // Expectations
  // ----------------------------------------
  function automatic logic allowed(int n, ivw_power_t p, logic m);
    logic allPs;
    allPs = (n >= 6 && n <= 15) || n == 26 || (n == 29 && m);
    case (p)
      IVW_RUN:   return !(n inside {0, 2, 3, 5, 16, 17, 23, 24});
      IVW_HALT:  return allPs;
      IVW_TIMED: return allPs || n == 4;
      default:   return allPs || n inside {1, 4, 18, 19, 20, 21, 22, 25, 27, 28, 29};
    endcase
  endfunction

  function automatic logic [23:0] vec(int n);
    return 24'h008008 + 24'(n) * 24'h000004;
  endfunction

  function automatic int lowest(logic [29:0] v);
    for (int i = 0; i < 30; i++) if (v[i] && allowed(i, IVW_RUN, 1'b0)) return i;
    return -1;
  endfunction

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tick();
    @(posedge clock);
    #1;
  endtask

  task automatic check(logic [23:0] seen, logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Enable dropped with the request, else the synchroniser tail re-vectors
  task automatic trial(logic exp, logic [23:0] addr);
    logic seen;
    seen = 1'b0;
    ackDelay = 2'($urandom);
    for (int k = 0; k < 10 && !seen; k++) begin
      tick();
      seen = vectorValid;
    end
    check(seen, exp);
    if (seen && exp) begin
      check(wakeCore, powerState != IVW_RUN);
      check(vectorAddr, addr);
    end
    {periphReq, irqEnable, resetReq, trapReq} = '0;
    for (int k = 0; k < 8 && vectorValid; k++) tick();
    if (seen && exp) check(takenAddr, addr);
    if (seen && exp && powerState == IVW_WFE) begin
      for (int k = 0; k < 4 && !returnToEventWait; k++) tick();
      // Reset restarts the core, it does not resume the event wait
      check(returnToEventWait, addr != 24'h008000);
    end
    repeat (8) tick();
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    void'($urandom(1024));
    repeat (12) @(posedge clock);
    #1;
    rst_b = 1'b1;
    for (int s = 1; s < 5; s++) begin
      powerState = pList[s];
      resetReq = 1'b1;
      trial(1'b1, 24'h008000);
      trapReq = 1'b1;
      trial(1'b0, 24'h000000);
    end
    powerState = IVW_RUN;
    trapReq = 1'b1;
    trial(1'b1, 24'h008004);
    $display("Reset and trap test done");
    foreach (pList[s]) begin
      for (int n = 0; n < 30; n++) begin
        powerState = pList[s];
        periphReq = 30'h1 << n;
        irqEnable = ~30'h0;
        irqEnable[n] = ($urandom % 4) != 0;
        i2cAddrMatch = 1'($urandom);
        trial(irqEnable[n] && allowed(n, pList[s], i2cAddrMatch), vec(n));
      end
    end
    $display("Source sweep test done");
    powerState = IVW_HALT;
    {periphReq, irqEnable} = '1;
    trial(1'b1, 24'h008020);
    powerState = IVW_RUN;
    periphReq = ~30'h0;
    irqEnable = 30'h3FFFFFFD;
    trial(1'b1, 24'h008018);
    {periphReq, irqEnable} = {30'h04000040, ~30'h0};
    trial(1'b1, 24'h008020);
    repeat (20) begin
      periphReq = 30'($urandom);
      irqEnable = 30'($urandom);
      lo = lowest(periphReq & irqEnable);
      trial(lo >= 0, vec(lo));
    end
    // Unused power code takes the all-ones mask of run, but still raises wakeCore
    powerState = 3'h5;
    periphReq = 30'h00040000;
    irqEnable = ~30'h0;
    trial(1'b1, 24'h008050);
    $display("Priority test done");
    stop_test();
  end
endmodule // irq_vector_wakeup_map_tb
`default_nettype wire
